// File: dual_pot_cmd_decoder.sv
`timescale 1ns/1ns
// Contract
// [R1] Address byte high nibble must match type
// [R2] Low address nibble must equal address pins
// [R3] Instruction: opcode, zero, pot, preset index
// [R4] Index bits pick preset zero to three
// [R5] Six-bit wiper per pot, one tap closed
// [R6] Wipers load preset zero at power-up
// [R7] Four six-bit presets per pot, host accessible
// [R8] Preset change programs within five milliseconds
// [R9] Opcodes 9,A,B,C read/write with data byte
// [R10] Opcodes D,E copy preset and wiper
// [R11] Opcodes 1,8 copy all pots globally
// [R12] Opcode 2 enables stepping the wiper
// [R13] After acknowledge each clock pulse steps once
// [R14] Pulse with data high increments wiper
// [R15] Pulse with data low decrements wiper
// [R16] Wiper-to-preset copy finishes within program time
// [R17] Tap follows wiper after settle delay
// [R18] No address acknowledge while programming
// [R19] Read sends eight bits, stops without acknowledge
// [R20] Stepping saturates at both ends
// [R21] Six data bits stored, upper bits read zero
module dual_pot_cmd_decoder
  import dual_pot_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE_ID = DEVICE_TYPE_ID_DEFAULT,
  parameter int NVM_CYCLES = NVM_PROGRAM_CYCLES,
  parameter int SETTLE_CYCLES = WIPER_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output wire logic sda_o,
  output wire logic sda_oe,
  input wire logic [3:0] hardwired_addr_pins,
  output wire logic [POTS-1:0][TAP_COUNT-1:0] tap_sel,
  output wire logic [POTS-1:0][WIPER_W-1:0] wiper_pos,
  output wire logic nvm_busy
);
  localparam int NVM_W = $clog2(NVM_CYCLES + 1);
  localparam int SET_W = $clog2(SETTLE_CYCLES + 1);

  if (NVM_CYCLES < 1 || SETTLE_CYCLES < 1) begin : g_bad_cfg
    $error("Cycle counts must be at least one");
  end

  function automatic logic [TAP_COUNT-1:0] tap_decode(
    input logic [WIPER_W-1:0] pos);
    tap_decode = TAP_RESET << pos;
  endfunction

  function automatic logic instr_valid(input logic [7:0] b);
    logic [3:0] op;
    logic idx_zero;
    op = b[7:INSTR_OP_LO];
    idx_zero = (b[INSTR_IDX_HI:0] == 2'h0);
    instr_valid = 1'b0;
    if (!b[INSTR_ZERO_BIT]) begin
      case (op)
        OP_RD_WIPER, OP_WR_WIPER, OP_STEP: instr_valid = idx_zero;
        OP_RD_PRESET, OP_WR_PRESET: instr_valid = 1'b1;
        OP_XFR_TO_WIPER, OP_XFR_TO_PRESET: instr_valid = 1'b1;
        OP_GXFR_TO_WIPER, OP_GXFR_TO_PRESET:
          instr_valid = !b[INSTR_POT_BIT];
        default: instr_valid = 1'b0;
      endcase
    end
  endfunction

  preset_bus_if pv ();

  preset_store_mem u_store (
    .clk(clk),
    .rstn(rstn),
    .bus(pv.store)
  );

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic [3:0] addr_s1_reg;
  logic [3:0] addr_s2_reg;
  link_state_t state_reg;
  link_state_t byte_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic ack_reg;
  logic tx_en_reg;
  logic tx_ack_reg;
  logic step_up_reg;
  logic [3:0] op_reg;
  logic pot_reg;
  logic [1:0] idx_reg;
  logic [1:0] recall_reg;
  logic pend_reg;
  logic [POTS-1:0] pend_en_reg;
  logic [1:0] pend_idx_reg;
  logic [POTS-1:0][WIPER_W-1:0] pend_data_reg;
  logic [NVM_W-1:0] nvm_cnt_reg;
  logic [WIPER_W-1:0] wiper_reg [POTS];
  logic [WIPER_W-1:0] target_reg [POTS];
  logic [SET_W-1:0] settle_cnt_reg [POTS];
  logic [TAP_COUNT-1:0] tap_reg [POTS];

  // Edge and condition detection on synchronised link lines
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_sync_reg[2];
  wire scl_fall = ~scl_s & scl_sync_reg[2];
  wire scl_hold = scl_s & scl_sync_reg[2];
  wire start_det = scl_hold & sda_sync_reg[2] & ~sda_s;
  wire stop_det = scl_hold & ~sda_sync_reg[2] & sda_s;

  wire busy = (nvm_cnt_reg != '0);
  wire [3:0] op_in = shift_reg[7:INSTR_OP_LO]; // [R3]
  wire pot_in = shift_reg[INSTR_POT_BIT]; // [R3]
  wire [1:0] idx_in = shift_reg[INSTR_IDX_HI:0]; // [R3] [R4]
  wire addr_match = (shift_reg[7:ADDR_TYPE_LO] == DEVICE_TYPE_ID) // [R1]
    && (shift_reg[ADDR_TYPE_LO-1:0] == addr_s2_reg) // [R2]
    && !busy; // [R18]
  wire instr_ok = instr_valid(shift_reg);
  wire byte_end = scl_fall && bit_cnt_reg == BIT_LAST
    && state_reg != S_INCDEC;
  wire ack_end = scl_fall && bit_cnt_reg == BIT_ACK;
  wire byte_accept = (state_reg == S_ADDR) ? addr_match :
    (state_reg == S_INSTR) ? instr_ok : (state_reg == S_RX);
  wire instr_done = byte_end && state_reg == S_INSTR && instr_ok;
  wire data_done = byte_end && state_reg == S_RX;
  wire step_ev = state_reg == S_INCDEC && scl_fall && !ack_reg; // [R13]
  wire [3:0] bit_cnt_next = (state_reg == S_INCDEC
    || bit_cnt_reg == BIT_ACK) ? BIT_FIRST : bit_cnt_reg + 4'h1;
  wire [WIPER_W-1:0] sel_wiper = wiper_reg[pot_reg];
  wire [7:0] tx_byte = (op_reg == OP_RD_WIPER) ?
    {2'b00, sel_wiper} : {2'b00, pv.rd_data[pot_reg]}; // [R9] [R21]

  always_comb begin
    case (state_reg)
      S_ADDR: byte_next = addr_match ? S_INSTR : S_IGNORE;
      S_INSTR: begin
        if (!instr_ok) begin
          byte_next = S_IGNORE;
        end else begin
          case (op_in)
            OP_RD_WIPER, OP_RD_PRESET: byte_next = S_TX;
            OP_WR_WIPER, OP_WR_PRESET: byte_next = S_RX;
            OP_STEP: byte_next = S_INCDEC; // [R12]
            default: byte_next = S_IGNORE;
          endcase
        end
      end
      S_TX: byte_next = S_TX;
      default: byte_next = S_IGNORE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin : sync_ff
    if (!rstn) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      addr_s1_reg <= 4'h0;
      addr_s2_reg <= 4'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      addr_s1_reg <= hardwired_addr_pins;
      addr_s2_reg <= addr_s1_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin : link_ff
    if (!rstn) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= BIT_FIRST;
      shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      ack_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      tx_ack_reg <= 1'b0;
      step_up_reg <= 1'b0;
      op_reg <= 4'h0;
      pot_reg <= 1'b0;
      idx_reg <= 2'h0;
    end else if (start_det) begin
      // The clock fall that ends the start closes a dummy slot
      state_reg <= S_ADDR;
      bit_cnt_reg <= BIT_ACK;
      ack_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end else if (stop_det || state_reg == S_IDLE) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= BIT_FIRST;
      ack_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end else begin
      if (scl_rise) begin
        shift_reg <= {shift_reg[6:0], sda_s};
        step_up_reg <= sda_s;
        if (bit_cnt_reg == BIT_ACK) begin
          tx_ack_reg <= ~sda_s; // [R19]
        end
      end
      if (scl_fall) begin
        bit_cnt_reg <= bit_cnt_next;
        if (byte_end) begin
          ack_reg <= byte_accept; // [R1] [R2]
          state_reg <= byte_next;
          tx_en_reg <= 1'b0; // [R19]
          if (state_reg == S_INSTR) begin
            op_reg <= op_in;
            pot_reg <= pot_in;
            idx_reg <= idx_in; // [R4]
          end
        end else if (ack_end) begin
          ack_reg <= 1'b0;
          if (state_reg == S_TX) begin
            if (tx_ack_reg) begin
              tx_shift_reg <= tx_byte;
              tx_en_reg <= 1'b1;
            end else begin
              state_reg <= S_IGNORE; // [R19]
            end
          end
        end else if (state_reg == S_TX) begin
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Open-drain data line: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = ack_reg | (tx_en_reg & ~tx_shift_reg[7]);

  // Read index follows the live byte so data is ready by byte end
  assign pv.rd_idx = (recall_reg != 2'h0) ? 2'h0 :
    (state_reg == S_INSTR) ? idx_in : idx_reg; // [R4] [R6]
  assign pv.wr_en = {POTS{stop_det & pend_reg}} & pend_en_reg; // [R7]
  assign pv.wr_idx = pend_idx_reg;
  assign pv.wr_data = pend_data_reg;
  assign nvm_busy = busy;

  always_ff @(posedge clk or negedge rstn) begin : nvm_ff
    if (!rstn) begin
      recall_reg <= RECALL_START;
      pend_reg <= 1'b0;
      pend_en_reg <= '0;
      pend_idx_reg <= 2'h0;
      pend_data_reg <= '0;
      nvm_cnt_reg <= '0;
    end else begin
      if (recall_reg != 2'h0) begin
        recall_reg <= recall_reg - 2'h1;
      end
      if (stop_det && pend_reg) begin
        pend_reg <= 1'b0;
        nvm_cnt_reg <= NVM_W'(NVM_CYCLES); // [R8] [R16]
      end else if (busy) begin
        nvm_cnt_reg <= nvm_cnt_reg - NVM_W'(1);
      end
      if (data_done && op_reg == OP_WR_PRESET) begin
        pend_reg <= 1'b1;
        pend_en_reg <= '0;
        pend_en_reg[pot_reg] <= 1'b1;
        pend_idx_reg <= idx_reg;
        pend_data_reg[pot_reg] <= shift_reg[WIPER_W-1:0]; // [R21]
      end else if (instr_done && (op_in == OP_XFR_TO_PRESET
          || op_in == OP_GXFR_TO_PRESET)) begin
        pend_reg <= 1'b1;
        pend_idx_reg <= idx_in;
        for (int p = 0; p < POTS; p++) begin
          pend_en_reg[p] <= op_in == OP_GXFR_TO_PRESET
            || pot_in == p[0]; // [R10] [R11]
          pend_data_reg[p] <= wiper_reg[p];
        end
      end
    end
  end

  for (genvar k = 0; k < POTS; k++) begin : g_pot
    wire own = (pot_reg == k);
    wire mem_load = (recall_reg == RECALL_LOAD) // [R6]
      || (instr_done && ((op_in == OP_XFR_TO_WIPER && pot_in == k)
      || op_in == OP_GXFR_TO_WIPER)); // [R10] [R11]
    wire host_load = data_done && op_reg == OP_WR_WIPER && own; // [R9]
    wire step_en = step_ev && own;
    wire [WIPER_W-1:0] up_val = (wiper_reg[k] == WIPER_MAX) ?
      wiper_reg[k] : wiper_reg[k] + WIPER_STEP; // [R14] [R20]
    wire [WIPER_W-1:0] dn_val = (wiper_reg[k] == '0) ?
      wiper_reg[k] : wiper_reg[k] - WIPER_STEP; // [R15] [R20]
    wire changed = wiper_reg[k] != target_reg[k];

    always_ff @(posedge clk or negedge rstn) begin : wiper_ff
      if (!rstn) begin
        wiper_reg[k] <= PRESET_RESET;
      end else if (mem_load) begin
        wiper_reg[k] <= pv.rd_data[k];
      end else if (host_load) begin
        wiper_reg[k] <= shift_reg[WIPER_W-1:0]; // [R21]
      end else if (step_en) begin
        wiper_reg[k] <= step_up_reg ? up_val : dn_val;
      end
    end

    // A new value restarts the settle count
    always_ff @(posedge clk or negedge rstn) begin : settle_ff
      if (!rstn) begin
        target_reg[k] <= PRESET_RESET;
        settle_cnt_reg[k] <= '0;
        tap_reg[k] <= TAP_RESET;
      end else if (changed) begin
        target_reg[k] <= wiper_reg[k];
        settle_cnt_reg[k] <= SET_W'(1);
      end else if (settle_cnt_reg[k] == SET_W'(SETTLE_CYCLES)) begin
        settle_cnt_reg[k] <= '0;
        tap_reg[k] <= tap_decode(target_reg[k]); // [R5] [R17]
      end else if (settle_cnt_reg[k] != '0) begin
        settle_cnt_reg[k] <= settle_cnt_reg[k] + SET_W'(1);
      end
    end

    assign tap_sel[k] = tap_reg[k];
    assign wiper_pos[k] = wiper_reg[k];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_addr_match;
    byte_end && state_reg == S_ADDR && !addr_match |=> !ack_reg;
  endproperty
  a_addr_match: assert property (p_addr_match) // [R2]
    else $error("Address acknowledged without a match");

  property p_busy_nack;
    busy && byte_end && state_reg == S_ADDR
      |=> !ack_reg && state_reg == S_IGNORE;
  endproperty
  a_busy_nack: assert property (p_busy_nack) // [R18]
    else $error("Address acknowledged while programming");

  property p_inc;
    step_ev && step_up_reg && sel_wiper != WIPER_MAX
      |=> sel_wiper == $past(sel_wiper) + WIPER_STEP;
  endproperty
  a_inc: assert property (p_inc) // [R14]
    else $error("Increment step wrong");

  property p_dec;
    step_ev && !step_up_reg && sel_wiper != '0
      |=> sel_wiper == $past(sel_wiper) - WIPER_STEP;
  endproperty
  a_dec: assert property (p_dec) // [R15]
    else $error("Decrement step wrong");

  property p_sat;
    step_ev && step_up_reg && sel_wiper == WIPER_MAX
      |=> sel_wiper == WIPER_MAX;
  endproperty
  a_sat: assert property (p_sat) // [R20]
    else $error("Wiper wrapped at top");

  // Window length is checked on the counter, too long for a delay
  property p_prog;
    stop_det && pend_reg
      |=> nvm_cnt_reg == NVM_W'(NVM_CYCLES) && !pend_reg;
  endproperty
  a_prog: assert property (p_prog) // [R8]
    else $error("Programming window start wrong");

  property p_prog_count;
    busy && !(stop_det && pend_reg)
      |=> nvm_cnt_reg == $past(nvm_cnt_reg) - NVM_W'(1);
  endproperty
  a_prog_count: assert property (p_prog_count) // [R16]
    else $error("Programming window count wrong");

  property p_tx_release;
    state_reg == S_TX && bit_cnt_reg == BIT_ACK |-> !tx_en_reg;
  endproperty
  a_tx_release: assert property (p_tx_release) // [R19]
    else $error("Data line driven during acknowledge slot");

  property p_tx_upper;
    tx_en_reg && bit_cnt_reg == BIT_FIRST && state_reg == S_TX
      |-> tx_shift_reg[7:6] == 2'b00;
  endproperty
  a_tx_upper: assert property (p_tx_upper) // [R21]
    else $error("Upper read bits not zero");

  property p_recall;
    recall_reg == RECALL_LOAD |=> wiper_reg[0] == $past(pv.rd_data[0]);
  endproperty
  a_recall: assert property (p_recall) // [R6]
    else $error("Power-up recall missing");

  property p_tap_onehot;
    $onehot(tap_reg[0]) && $onehot(tap_reg[1]);
  endproperty
  a_tap_onehot: assert property (p_tap_onehot) // [R5]
    else $error("Tap select not one-hot");

  property p_settle;
    $changed(tap_reg[0]) |-> $past(settle_cnt_reg[0]) ==
      SET_W'(SETTLE_CYCLES);
  endproperty
  a_settle: assert property (p_settle) // [R17]
    else $error("Tap moved before settle delay");

  c_step: cover property (step_ev);
  c_program: cover property (stop_det && pend_reg);
  c_read: cover property (state_reg == S_TX && ack_end && tx_ack_reg);
  c_addr_ack: cover property (byte_end && state_reg == S_ADDR
    && addr_match);
endmodule // dual_pot_cmd_decoder

// File: dual_pot_pkg.sv
package dual_pot_pkg;
  localparam int POTS = 2;
  localparam int WIPER_W = 6;
  localparam int PRESETS = 4;
  localparam int TAP_COUNT = 64;
  localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3F;
  localparam logic [WIPER_W-1:0] WIPER_STEP = 6'h01;
  localparam logic [WIPER_W-1:0] PRESET_RESET = 6'h00;
  localparam logic [TAP_COUNT-1:0] TAP_RESET = 64'h0000_0000_0000_0001;
  // Device type code: value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_ID_DEFAULT = 4'h3;
  // Address byte fields
  localparam int ADDR_TYPE_LO = 4;
  // Instruction byte fields
  localparam int INSTR_OP_LO = 4;
  localparam int INSTR_ZERO_BIT = 3;
  localparam int INSTR_POT_BIT = 2;
  localparam int INSTR_IDX_HI = 1;
  localparam logic [3:0] OP_GXFR_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_GXFR_TO_PRESET = 4'h8;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_PRESET = 4'hB;
  localparam logic [3:0] OP_WR_PRESET = 4'hC;
  localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
  localparam logic [3:0] OP_XFR_TO_PRESET = 4'hE;
  // Bit counter landmarks within a nine-clock byte slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] RECALL_START = 2'h2;
  localparam logic [1:0] RECALL_LOAD = 2'h1;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int NVM_PROGRAM_TIME_MS = 5;
  localparam int NVM_PROGRAM_CYCLES =
    NVM_PROGRAM_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WIPER_SETTLE_NS = 1000;
  localparam int WIPER_SETTLE_CYCLES =
    (WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_INSTR, S_RX, S_TX, S_INCDEC, S_IGNORE
  } link_state_t;
endpackage

// File: i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // Idle bus: both lines released to the pull-up, clock stands high
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start_cond();
    sda_drv = 1'h1;
    gap(5);
    scl = 1'h1;
    gap(5);
    sda_drv = 1'h0;
    gap(5);
    scl = 1'h0;
    gap(5);
  endtask

  task automatic stop_cond();
    sda_drv = 1'h0;
    gap(5);
    scl = 1'h1;
    gap(5);
    sda_drv = 1'h1;
    gap(10);
  endtask

  // One 160 ns pulse; data moves only while the clock is low
  task automatic bit_cycle(input logic b, output logic r);
    sda_drv = b;
    gap(5);
    scl = 1'h1;
    gap(5);
    r = sda_line;
    gap(5);
    scl = 1'h0;
    gap(5);
  endtask

  // Most significant bit first, ninth pulse left to the device
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], r);
    end
    bit_cycle(1'h1, r);
    ack = ~r;
  endtask

  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'h1, d[i]);
    end
    bit_cycle(~mack, r);
  endtask
endmodule // i2c_master_model

// File: preset_bus_if.sv
`timescale 1ns/1ns
interface preset_bus_if;
  import dual_pot_pkg::*;
  logic [1:0] rd_idx;
  logic [POTS-1:0][WIPER_W-1:0] rd_data;
  logic [POTS-1:0] wr_en;
  logic [1:0] wr_idx;
  logic [POTS-1:0][WIPER_W-1:0] wr_data;
  modport ctrl (output rd_idx, output wr_en, output wr_idx,
    output wr_data, input rd_data);
  modport store (input rd_idx, input wr_en, input wr_idx,
    input wr_data, output rd_data);
endinterface

// File: preset_store_mem.sv
`timescale 1ns/1ns
module preset_store_mem
  import dual_pot_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  preset_bus_if.store bus
);
  logic [WIPER_W-1:0] cell_reg [POTS][PRESETS];
  logic [POTS-1:0][WIPER_W-1:0] rd_data_reg;

  // Both pots read at one index so global transfers need one access
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < POTS; p++) begin
        rd_data_reg[p] <= PRESET_RESET;
        for (int i = 0; i < PRESETS; i++) begin
          cell_reg[p][i] <= PRESET_RESET;
        end
      end
    end else begin
      for (int p = 0; p < POTS; p++) begin
        if (bus.wr_en[p]) begin
          cell_reg[p][bus.wr_idx] <= bus.wr_data[p];
        end
        rd_data_reg[p] <= cell_reg[p][bus.rd_idx];
      end
    end
  end

  assign bus.rd_data = rd_data_reg;
endmodule // preset_store_mem

// File: tb_dual_pot_i2c_command_decoder.sv
`timescale 1ns/1ns
module tb_dual_pot_i2c_command_decoder;
  import dual_pot_pkg::*;
  // Device type code: value is arbitrary
  localparam logic [3:0] TYPE_ID = 4'h3;
  localparam logic [3:0] PINS = 4'hA;
  localparam logic [7:0] ADDR = {TYPE_ID, PINS};
  localparam int NVM_T = 400;
  localparam int SETTLE_T = 4;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic scl;
  logic sda_drv;
  wire logic sda_oe;
  wire logic sda_o;
  wire logic sda_line;
  wire logic [POTS-1:0][TAP_COUNT-1:0] tap_sel;
  wire logic [POTS-1:0][WIPER_W-1:0] wiper_pos;
  wire logic nvm_busy;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  logic ack;
  logic [7:0] rd;
  logic [7:0] bad [5] = '{8'h28, 8'h91, 8'h16, 8'h21, 8'h00};

  always #4 clk = ~clk;

  // Open-drain data line with pull-up
  assign sda_line = sda_drv & (~sda_oe | sda_o);

  i2c_master_model m (
    .clk(clk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_drv(sda_drv)
  );

  dual_pot_cmd_decoder #(
    .DEVICE_TYPE_ID(TYPE_ID),
    .NVM_CYCLES(NVM_T),
    .SETTLE_CYCLES(SETTLE_T)
  ) uut (
    .clk(clk),
    .rstn(rstn),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .hardwired_addr_pins(PINS),
    .tap_sel(tap_sel),
    .wiper_pos(wiper_pos),
    .nvm_busy(nvm_busy)
  );

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Start, own address, instruction; leaves the instruction ack in ack
  task automatic head(input logic [7:0] ins);
    m.start_cond();
    m.put_byte(ADDR, ack);
    check(ack, 1'h1);
    m.put_byte(ins, ack);
  endtask

  task automatic write_cmd(input logic [7:0] ins, input logic [7:0] dat,
      input bit three);
    head(ins);
    check(ack, 1'h1);
    if (three) begin
      m.put_byte(dat, ack);
      check(ack, 1'h1);
    end
    m.stop_cond();
  endtask

  // Reads twice: the acked byte must repeat in the second
  task automatic read_cmd(input logic [7:0] ins, output logic [7:0] d);
    logic [7:0] first;
    head(ins);
    check(ack, 1'h1);
    m.get_byte(1'h1, first);
    m.get_byte(1'h0, d);
    m.stop_cond();
    check(d, first);
  endtask

  task automatic probe(input logic [7:0] a, output logic got);
    m.start_cond();
    m.put_byte(a, got);
    m.stop_cond();
  endtask

  task automatic step_cmd(input logic [7:0] ins, input logic [7:0] dirs,
      input int n);
    logic r;
    head(ins);
    check(ack, 1'h1);
    for (int i = n - 1; i >= 0; i--) begin
      m.bit_cycle(dirs[i], r);
    end
    m.stop_cond();
  endtask

  task automatic wait_nvm();
    repeat (NVM_T) begin
      if (nvm_busy === 1'h1)
        @(negedge clk);
    end
    check(nvm_busy, 1'h0);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'h1;
    repeat (8) @(negedge clk);
    check(wiper_pos, 64'h0);
    check(tap_sel[0], TAP_RESET);
    check(nvm_busy, 1'h0);
    probe({~TYPE_ID, PINS}, ack);
    check(ack, 1'h0);
    probe({TYPE_ID, ~PINS}, ack);
    check(ack, 1'h0);
    foreach (bad[i]) begin
      head(bad[i]);
      m.stop_cond();
      check(ack, 1'h0);
    end
    write_cmd(8'hA4, 8'hFF, 1);
    check(wiper_pos[1], 6'h3F);
    check(tap_sel[1], 64'h1 << 63);
    fork
      write_cmd(8'hA0, 8'h15, 1);
      begin
        @(wiper_pos[0]);
        #1 check(tap_sel[0], TAP_RESET);
        repeat (SETTLE_T + 3) @(negedge clk);
        check(tap_sel[0], 64'h1 << 21);
      end
    join
    read_cmd(8'h94, rd);
    check(rd, 8'h3F);
    read_cmd(8'h90, rd);
    check(rd, 8'h15);
    write_cmd(8'hC3, 8'hEA, 1);
    check(nvm_busy, 1'h1);
    probe(ADDR, ack);
    check(ack, 1'h0);
    wait_nvm();
    probe(ADDR, ack);
    check(ack, 1'h1);
    read_cmd(8'hB3, rd);
    check(rd, 8'h2A);
    write_cmd(8'hD3, 8'h00, 0);
    check(wiper_pos[0], 6'h2A);
    write_cmd(8'hE5, 8'h00, 0);
    wait_nvm();
    read_cmd(8'hB5, rd);
    check(rd, 8'h3F);
    write_cmd(8'h82, 8'h00, 0);
    wait_nvm();
    step_cmd(8'h24, 8'h18, 5);
    check(wiper_pos[1], 6'h3C);
    write_cmd(8'hA0, 8'h01, 1);
    step_cmd(8'h20, 8'h00, 3);
    check(wiper_pos[0], 6'h00);
    write_cmd(8'h12, 8'h00, 0);
    check(wiper_pos, {6'h3F, 6'h2A});
    summarize();
  end
endmodule // tb_dual_pot_i2c_command_decoder
